// *** inc/scp_pkg.sv ***
// package of constants and types for the start-up configuration loader
package scp_pkg;

  // three-level strap pin encoding
  localparam logic [1:0] SCP_LVL_LOW   = 2'h0;
  localparam logic [1:0] SCP_LVL_HIGH  = 2'h1;
  localparam logic [1:0] SCP_LVL_FLOAT = 2'h2;

  // strap widths and counts
  localparam int SCP_STRAP_W  = 3;
  localparam int SCP_NGROUP   = 4;
  localparam int SCP_SYNC_LEN = 2;

  // i2c address base: port-select code k maps to base + k - 1
  localparam logic [6:0] SCP_I2C_BASE = 7'h39;
  localparam logic [6:0] SCP_I2C_LAST = 7'h3f;

  // spi port configuration register address, inside the port logic
  localparam logic [14:0] SCP_SPI_CFG_ADDR = 15'h0000;
  localparam logic [7:0]  SCP_SPI_CFG_RST  = 8'h00;

  // reserved strap combination
  localparam logic [2:0] SCP_RSVD_CODE = 3'h7;

  // timing: settle and calibration times
  localparam int SCP_CLK_MHZ       = 100;
  localparam int SCP_SETTLE_US     = 10;
  localparam int SCP_SETTLE_CYC    = SCP_SETTLE_US * SCP_CLK_MHZ;
  localparam int SCP_CAL_US        = 20;
  localparam int SCP_CAL_CYC       = SCP_CAL_US * SCP_CLK_MHZ;

  // drive formats
  typedef enum logic [2:0] {
    SCP_FMT_OFF  = 3'h0,
    SCP_FMT_HSTL = 3'h1,
    SCP_FMT_LVDS = 3'h2,
    SCP_FMT_HCSL = 3'h3,
    SCP_FMT_CMOS = 3'h4
  } scp_fmt_t;

  // serial protocol
  typedef enum logic [1:0] {
    SCP_PORT_NONE = 2'h0,
    SCP_PORT_SPI  = 2'h1,
    SCP_PORT_I2C  = 2'h2
  } scp_port_t;

  // start-up sequence, gray along the normal path
  typedef enum logic [2:0] {
    SCP_ST_SUPPLY = 3'b000,
    SCP_ST_LDO    = 3'b001,
    SCP_ST_SCAN   = 3'b011,
    SCP_ST_CAL    = 3'b010,
    SCP_ST_LOCK   = 3'b110,
    SCP_ST_RUN    = 3'b111
  } scp_state_t;

endpackage

// *** rtl/scp_strap_decode.sv ***
// combinational decode of sampled straps into port choice and output setup
module scp_strap_decode
  import scp_pkg::*;
(
  // straps
  input  wire logic [1:0]             port_select_strap_a,
  input  wire logic [1:0]             port_select_strap_b,
  input  wire logic [SCP_STRAP_W-1:0] first_preset_strap,
  input  wire logic [SCP_STRAP_W-1:0] third_preset_strap,
  input  wire logic [SCP_STRAP_W-1:0] fourth_preset_strap,
  // decoded
  output scp_port_t                   port_sel,
  output logic [6:0]                  i2c_addr,
  output logic                        spi_strap_load,
  output logic                        doubler_en,
  output logic                        cfg_valid,
  output logic                        ref_19_30,
  output logic [SCP_NGROUP-1:0]       grp_en,
  output logic                        grp_src_int
);

  // selects map to a 0..8 code, a weighted by three
  function automatic logic [3:0] lvl_code(input logic [1:0] b, input logic [1:0] a);
    logic [3:0] cb;
    logic [3:0] ca;
    cb = (b == SCP_LVL_FLOAT) ? 4'h0 : (b == SCP_LVL_LOW) ? 4'h1 : 4'h2;
    ca = (a == SCP_LVL_FLOAT) ? 4'h0 : (a == SCP_LVL_LOW) ? 4'h3 : 4'h6;
    return cb + ca;
  endfunction

  logic [3:0] ps_code;
  logic [5:0] combo;

  assign ps_code = lvl_code(port_select_strap_b, port_select_strap_a);
  assign combo   = {third_preset_strap, fourth_preset_strap};

  always_comb begin
    port_sel       = SCP_PORT_I2C;
    i2c_addr       = 7'h00;
    spi_strap_load = 1'b0;
    if (ps_code == 4'h0) begin
      port_sel       = SCP_PORT_SPI;
      spi_strap_load = 1'b1;
    end else if (ps_code == 4'h8) begin
      port_sel = SCP_PORT_SPI;
    end else begin
      i2c_addr = SCP_I2C_BASE + 7'(ps_code - 4'h1);
    end
  end

  // 0x30..0x36 need doubler; 0x37..0x3e are the 19.44/30.72 codes
  always_comb begin
    doubler_en = (combo >= 6'h30) && (combo <= 6'h36);
    ref_19_30  = (combo >= 6'h37) && (combo <= 6'h3e);
    cfg_valid  = 1'b1;
    if (combo == {SCP_RSVD_CODE, SCP_RSVD_CODE}) begin
      cfg_valid = 1'b0;
    end else if (doubler_en && (first_preset_strap == 3'h2 || first_preset_strap == 3'h3)) begin
      cfg_valid = 1'b0;
    end else if (ref_19_30 && first_preset_strap < 3'h4) begin
      cfg_valid = 1'b0;
    end
  end

  // table condensed to group enables and source loop
  always_comb begin
    grp_en      = (combo == 6'h00) ? '0 : '1;
    grp_src_int = 1'b1;
    if (combo == 6'h01 || combo == 6'h02 || combo == 6'h0a || combo == 6'h0b
        || combo == 6'h0f || combo == 6'h10 || (combo >= 6'h13 && combo <= 6'h1b)
        || combo == 6'h1e || combo == 6'h1f || combo == 6'h20 || combo == 6'h21
        || combo == 6'h26 || combo == 6'h3b || combo == 6'h3c) begin
      grp_src_int = 1'b0;
    end
  end

endmodule

// *** rtl/scp_startup.sv ***
// power-on sequencer, strap loader, lock outputs and serial port selection
module scp_startup
  import scp_pkg::*;
#(
  parameter int SETTLE_CYC = SCP_SETTLE_CYC,
  parameter int CAL_CYC    = SCP_CAL_CYC
)(
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // supply and regulator monitors
  input  wire logic                   supply_ok,
  input  wire logic                   ldo_ok,
  output logic                        ldo_en_q,
  // straps (pins; port selects three-level encoded, presets binary)
  input  wire logic [1:0]             port_select_strap_a,
  input  wire logic [1:0]             port_select_strap_b,
  input  wire logic [SCP_STRAP_W-1:0] first_preset_strap,
  input  wire logic [SCP_STRAP_W-1:0] third_preset_strap,
  input  wire logic [SCP_STRAP_W-1:0] fourth_preset_strap,
  // references and analog lock detectors
  input  wire logic                   ref_frac_ok,
  input  wire logic                   ref_int_ok,
  input  wire logic                   frac_lock_raw,
  input  wire logic                   int_lock_raw,
  // loop control
  output logic                        frac_cal_start_q,
  output logic                        int_lock_en_q,
  output logic                        doubler_en_q,
  output logic                        frac_pll_lock_out,
  output logic                        int_pll_lock_out,
  output logic                        frac_prescale_en_q,
  output logic                        int_prescale_en_q,
  output logic [SCP_NGROUP-1:0]       grp_toggle_en_q,
  // configuration status
  output logic                        cfg_done_q,
  output logic                        cfg_err_q,
  // serial port selection
  output logic                        spi_active_q,
  output logic                        i2c_active_q,
  output logic [6:0]                  i2c_addr_q,
  output logic                        spi_strap_load_q,
  output logic                        sdio_3wire_q,
  output logic [7:0]                  spi_cfg_q,
  output logic                        regmap_access_en_q,
  // spi port config write (from the shifter)
  input  wire logic                   spi_cfg_wr,
  input  wire logic [14:0]            spi_cfg_addr,
  input  wire logic [7:0]             spi_cfg_wdata
);

  if (SETTLE_CYC < 1 || CAL_CYC < 1) begin : g_bad_cnt
    $error("counts must be at least one");
  end

  localparam int CW = $clog2(SETTLE_CYC > CAL_CYC ? SETTLE_CYC + 1 : CAL_CYC + 1);
  localparam int NIN = 15;

  // two-flop synchronisers for every pin input
  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  assign pin_raw = {supply_ok, ldo_ok, ref_frac_ok, ref_int_ok, frac_lock_raw, int_lock_raw,
                    first_preset_strap, third_preset_strap, fourth_preset_strap};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
    end
  end

  // port selects are three-level: separate synchroniser, float as reset value
  logic [3:0] ps1_q;
  logic [3:0] ps2_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ps1_q <= {SCP_LVL_FLOAT, SCP_LVL_FLOAT};
      ps2_q <= {SCP_LVL_FLOAT, SCP_LVL_FLOAT};
    end else begin
      ps1_q <= {port_select_strap_b, port_select_strap_a};
      ps2_q <= ps1_q;
    end
  end

  logic                   sup_s;
  logic                   ldo_s;
  logic                   rfr_s;
  logic                   rin_s;
  logic                   lkf_s;
  logic                   lki_s;
  logic [SCP_STRAP_W-1:0] p0_s;
  logic [SCP_STRAP_W-1:0] p2_s;
  logic [SCP_STRAP_W-1:0] p3_s;
  assign {sup_s, ldo_s, rfr_s, rin_s, lkf_s, lki_s, p0_s, p2_s, p3_s} = s2_q;

  // decode of synchronised straps
  scp_port_t              dec_port;
  logic [6:0]             dec_addr;
  logic                   dec_load;
  logic                   dec_dbl;
  logic                   dec_valid;
  logic [SCP_NGROUP-1:0]  dec_grp;

  scp_strap_decode u_dec (
    .port_select_strap_a (ps2_q[1:0]),
    .port_select_strap_b (ps2_q[3:2]),
    .first_preset_strap  (p0_s),
    .third_preset_strap  (p2_s),
    .fourth_preset_strap (p3_s),
    .port_sel            (dec_port),
    .i2c_addr            (dec_addr),
    .spi_strap_load      (dec_load),
    .doubler_en          (dec_dbl),
    .cfg_valid           (dec_valid),
    .ref_19_30           (),
    .grp_en              (dec_grp),
    .grp_src_int         ()
  );

  // sequencer state
  scp_state_t            st_q;
  scp_state_t            st_d;
  logic [CW-1:0]         cnt_q;
  logic [CW-1:0]         cnt_d;
  logic                  ldo_en_d;
  logic                  cal_d;
  logic                  ilk_d;
  logic                  cfg_done_d;
  logic                  cfg_err_d;
  logic                  dbl_d;
  logic [SCP_NGROUP-1:0] grp_cfg_q;
  logic [SCP_NGROUP-1:0] grp_cfg_d;
  logic                  cal_done_q;
  logic                  cal_done_d;

  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    ldo_en_d   = ldo_en_q;
    cal_d      = 1'b0;
    ilk_d      = int_lock_en_q;
    cfg_done_d = cfg_done_q;
    cfg_err_d  = cfg_err_q;
    dbl_d      = doubler_en_q;
    grp_cfg_d  = grp_cfg_q;
    cal_done_d = cal_done_q;
    case (st_q)
      SCP_ST_SUPPLY: begin
        if (sup_s) begin
          st_d     = SCP_ST_LDO;
          ldo_en_d = 1'b1;
        end
      end
      SCP_ST_LDO: begin
        // regulator must read good for a settle time before the scan
        if (!ldo_s) begin
          cnt_d = '0;
        end else if (cnt_q == CW'(SETTLE_CYC - 1)) begin
          st_d  = SCP_ST_SCAN;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      SCP_ST_SCAN: begin
        cfg_done_d = 1'b1;
        cfg_err_d  = !dec_valid;
        dbl_d      = dec_dbl;
        grp_cfg_d  = dec_valid ? dec_grp : '0;
        ilk_d      = 1'b1;
        st_d       = SCP_ST_CAL;
      end
      SCP_ST_CAL: begin
        // calibration only runs while the reference is present
        if (rfr_s) begin
          cal_d = (cnt_q == '0);
          if (cnt_q == CW'(CAL_CYC - 1)) begin
            st_d       = SCP_ST_LOCK;
            cal_done_d = 1'b1;
            cnt_d      = '0;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end else begin
          cnt_d = '0;
        end
      end
      SCP_ST_LOCK: begin
        st_d = SCP_ST_RUN;
      end
      SCP_ST_RUN: begin
        st_d = SCP_ST_RUN;
      end
      default: begin
        st_d = SCP_ST_SUPPLY;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q             <= SCP_ST_SUPPLY;
      cnt_q            <= '0;
      ldo_en_q         <= 1'b0;
      frac_cal_start_q <= 1'b0;
      int_lock_en_q    <= 1'b0;
      cfg_done_q       <= 1'b0;
      cfg_err_q        <= 1'b0;
      doubler_en_q     <= 1'b0;
      grp_cfg_q        <= '0;
      cal_done_q       <= 1'b0;
    end else begin
      st_q             <= st_d;
      cnt_q            <= cnt_d;
      ldo_en_q         <= ldo_en_d;
      frac_cal_start_q <= cal_d;
      int_lock_en_q    <= ilk_d;
      cfg_done_q       <= cfg_done_d;
      cfg_err_q        <= cfg_err_d;
      doubler_en_q     <= dbl_d;
      grp_cfg_q        <= grp_cfg_d;
      cal_done_q       <= cal_done_d;
    end
  end

  // lock outputs and prescaler enables
  logic                  flk_d;
  logic                  ilk_out_d;
  logic [SCP_NGROUP-1:0] tog_d;

  always_comb begin
    // fractional lock is honoured only after calibration with a reference
    flk_d     = cal_done_q && rfr_s && lkf_s;
    ilk_out_d = int_lock_en_q && rin_s && lki_s;
    // groups 0..2 follow the fractional loop, group 3 either loop; gate by straps
    tog_d     = grp_cfg_q & {(frac_pll_lock_out | int_pll_lock_out),
                             {(SCP_NGROUP-1){frac_pll_lock_out}}};
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frac_pll_lock_out  <= 1'b0;
      int_pll_lock_out   <= 1'b0;
      frac_prescale_en_q <= 1'b0;
      int_prescale_en_q  <= 1'b0;
      grp_toggle_en_q    <= '0;
    end else begin
      frac_pll_lock_out  <= flk_d;
      int_pll_lock_out   <= ilk_out_d;
      frac_prescale_en_q <= frac_pll_lock_out;
      int_prescale_en_q  <= int_pll_lock_out;
      grp_toggle_en_q    <= tog_d;
    end
  end

  // serial port choice: latched once in the scan state, held until reset
  logic       spi_d;
  logic       i2c_d;
  logic [6:0] addr_d;
  logic       load_d;
  logic [7:0] spi_cfg_d;

  always_comb begin
    spi_d     = spi_active_q;
    i2c_d     = i2c_active_q;
    addr_d    = i2c_addr_q;
    load_d    = spi_strap_load_q;
    spi_cfg_d = spi_cfg_q;
    if (st_q == SCP_ST_SCAN && !spi_active_q && !i2c_active_q) begin
      spi_d  = (dec_port == SCP_PORT_SPI);
      i2c_d  = (dec_port == SCP_PORT_I2C);
      addr_d = dec_addr;
      load_d = dec_load;
    end
    // port config sits in the port logic, never forwarded to the map
    if (spi_active_q && spi_cfg_wr && spi_cfg_addr == SCP_SPI_CFG_ADDR) begin
      spi_cfg_d = spi_cfg_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      spi_active_q       <= 1'b0;
      i2c_active_q       <= 1'b0;
      i2c_addr_q         <= 7'h00;
      spi_strap_load_q   <= 1'b0;
      sdio_3wire_q       <= 1'b0;
      spi_cfg_q          <= SCP_SPI_CFG_RST;
      regmap_access_en_q <= 1'b0;
    end else begin
      spi_active_q       <= spi_d;
      i2c_active_q       <= i2c_d;
      i2c_addr_q         <= addr_d;
      spi_strap_load_q   <= load_d;
      sdio_3wire_q       <= spi_d;
      spi_cfg_q          <= spi_cfg_d;
      regmap_access_en_q <= spi_d | i2c_d;
    end
  end

endmodule

// *** testbench/scp_startup_chk.sv ***
// concurrent checks on the start-up loader ports
module scp_chk
  import scp_pkg::*;
#(
  parameter int SETTLE_CYC = SCP_SETTLE_CYC,
  parameter int CAL_CYC    = SCP_CAL_CYC
)(
  // clock, reset, monitors
  input wire logic         clk_sys, rst, supply_ok, ldo_ok, ldo_en_q,
  input wire logic         ref_int_ok, int_lock_raw,
  // straps
  input wire logic [2:0]   third_preset_strap, fourth_preset_strap,
  // loop and config outputs
  input wire logic         frac_cal_start_q, int_lock_en_q, frac_pll_lock_out,
  input wire logic         int_pll_lock_out, frac_prescale_en_q, cfg_done_q, cfg_err_q,
  input wire logic [3:0]   grp_toggle_en_q,
  // serial port
  input wire logic         spi_active_q, i2c_active_q, spi_cfg_wr,
  input wire logic [6:0]   i2c_addr_q,
  input wire logic [7:0]   spi_cfg_q, spi_cfg_wdata,
  input wire logic [14:0]  spi_cfg_addr
);
  // counters saturate so a long run cannot wrap into a false pass
  logic        cal_seen_q, cal_seen_d;
  logic [15:0] cal_cnt_q, cal_cnt_d, ldo_run_q, ldo_run_d;

  always_comb begin
    cal_seen_d = cal_seen_q | frac_cal_start_q;
    cal_cnt_d  = frac_cal_start_q ? 16'h0001 :
                 cal_cnt_q + {15'h0000, cal_seen_q && cal_cnt_q != 16'hffff};
    ldo_run_d  = !ldo_ok ? 16'h0000 : ldo_run_q + {15'h0000, ldo_run_q != 16'hffff};
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cal_seen_q <= 1'b0;
      cal_cnt_q  <= 16'h0000;
      ldo_run_q  <= 16'h0000;
    end else begin
      cal_seen_q <= cal_seen_d;
      cal_cnt_q  <= cal_cnt_d;
      ldo_run_q  <= ldo_run_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_LDO_AFTER_SUPPLY: assert property ($rose(ldo_en_q) |-> $past(supply_ok, 2))
    else $error("regulator enabled without valid supply");
  AST_SCAN_AFTER_SETTLE: assert property ($rose(cfg_done_q) |->
    ldo_en_q && ldo_run_q >= SETTLE_CYC) else $error("config loaded before settle");
  AST_ONE_PORT: assert property (cfg_done_q |-> spi_active_q != i2c_active_q)
    else $error("serial port choice not exclusive");
  AST_PORT_HELD: assert property ($past(cfg_done_q) |->
    $stable({spi_active_q, i2c_active_q, i2c_addr_q})) else $error("port choice changed");
  AST_I2C_ADDR: assert property (i2c_active_q |->
    i2c_addr_q inside {[SCP_I2C_BASE:SCP_I2C_LAST]}) else $error("i2c address out of range");
  AST_CAL_FIRST: assert property ($rose(frac_pll_lock_out) |->
    cal_seen_q && cal_cnt_q >= CAL_CYC - 1) else $error("fractional lock before calibration");
  AST_INT_LOCK: assert property ($rose(int_pll_lock_out) |-> int_lock_en_q &&
    $past(int_lock_raw, 2) && $past(ref_int_ok, 2)) else $error("integer lock pin unfounded");
  AST_PRESCALE: assert property ($rose(frac_pll_lock_out) |=> frac_prescale_en_q)
    else $error("prescaler not enabled after lock");
  AST_RSVD: assert property ($rose(cfg_done_q) && third_preset_strap == SCP_RSVD_CODE &&
    fourth_preset_strap == SCP_RSVD_CODE |-> cfg_err_q && grp_toggle_en_q == 4'h0)
    else $error("reserved strap not refused");
  AST_SPI_CFG_WR: assert property (spi_active_q && spi_cfg_wr &&
    spi_cfg_addr == SCP_SPI_CFG_ADDR |=> spi_cfg_q == $past(spi_cfg_wdata))
    else $error("port config write lost");
  AST_SPI_CFG_KEEP: assert property (!(spi_active_q && spi_cfg_wr &&
    spi_cfg_addr == SCP_SPI_CFG_ADDR) |=> $stable(spi_cfg_q)) else $error("port config changed");
endmodule

bind scp_startup scp_chk #(.SETTLE_CYC(SETTLE_CYC), .CAL_CYC(CAL_CYC)) CHK (.*);

// *** testbench/scp_board.sv ***
// board-side model: supply, regulator, references and analog lock detectors
module scp_board
  import scp_pkg::*;
(
  // control from the bench
  input  wire logic       clk_sys,
  input  wire logic       pwr_on,
  input  wire logic       ref_on,
  input  wire logic [3:0] dly,
  // from the device
  input  wire logic       ldo_en_q,
  input  wire logic       frac_cal_start_q,
  input  wire logic       int_lock_en_q,
  // to the device
  output logic            supply_ok,
  output logic            ldo_ok,
  output logic            ref_frac_ok,
  output logic            ref_int_ok,
  output logic            frac_lock_raw,
  output logic            int_lock_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  int lc = 0;
  int fc = 0;
  int ic = 0;

  initial {supply_ok, ldo_ok, ref_frac_ok, ref_int_ok, frac_lock_raw, int_lock_raw} = '0;

  // dly sets how slowly regulator and loops respond
  always @(negedge clk_sys) begin
    lc = ldo_en_q ? lc + 1 : 0;
    fc = !ldo_en_q ? 0 : (frac_cal_start_q ? 1 : (fc > 0 ? fc + 1 : 0));
    ic = int_lock_en_q ? ic + 1 : 0;
    supply_ok     <= pwr_on;
    ldo_ok        <= ldo_en_q && lc > dly;
    ref_frac_ok   <= ref_on;
    ref_int_ok    <= ref_on;
    // lock is lost with the reference, never held over it
    frac_lock_raw <= ref_on && fc > dly;
    int_lock_raw  <= ref_on && ic > dly;
  end
endmodule

// *** testbench/tb_strap_config_por_port_select.sv ***
// self-checking bench for the start-up configuration loader
module tb_strap_config_por_port_select
  import scp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 4;
  localparam int CAL    = 8;
  logic        clk_sys = 1'b0, rst = 1'b1, pwr_on = 1'b0, ref_on = 1'b0, cfg_wr = 1'b0;
  logic [3:0]  dly = 4'h1;
  logic [1:0]  ps_a = SCP_LVL_FLOAT, ps_b = SCP_LVL_FLOAT;
  logic [2:0]  p0 = 3'h0, p2 = 3'h0, p3 = 3'h1;
  logic [7:0]  cfg_wdata = 8'h00, spi_cfg_q;
  logic [14:0] cfg_addr = 15'h0000;
  logic        supply_ok, ldo_ok, ldo_en_q, ref_frac_ok, ref_int_ok, frac_lock_raw;
  logic        int_lock_raw, frac_cal_start_q, int_lock_en_q, doubler_en_q, cfg_done_q;
  logic        frac_pll_lock_out, int_pll_lock_out, frac_prescale_en_q, int_prescale_en_q;
  logic        cfg_err_q, spi_active_q, i2c_active_q, spi_strap_load_q, sdio_3wire_q;
  logic        regmap_access_en_q;
  logic [3:0]  grp_toggle_en_q;
  logic [6:0]  i2c_addr_q;
  int          num_errors = 0, n_checks = 0, cyc = 0, cal_seen = 0;

  scp_startup #(.SETTLE_CYC(SETTLE), .CAL_CYC(CAL)) DUT (
    .*,
    .port_select_strap_a(ps_a),
    .port_select_strap_b(ps_b),
    .first_preset_strap(p0),
    .third_preset_strap(p2),
    .fourth_preset_strap(p3),
    .spi_cfg_wr(cfg_wr),
    .spi_cfg_addr(cfg_addr),
    .spi_cfg_wdata(cfg_wdata)
  );
  scp_board BRD (.*);

  always #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (frac_cal_start_q === 1'b1) cal_seen++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // reset with new straps, hold supply off, then power up
  task automatic boot(input logic [1:0] a, b, input logic [2:0] f0, f2, f3);
    @(negedge clk_sys);
    rst = 1'b1;
    pwr_on = 1'b0;
    {ps_a, ps_b, p0, p2, p3} = {a, b, f0, f2, f3};
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    cal_seen = 0;
    repeat (8) @(negedge clk_sys);
    chk(ldo_en_q, 8'h00);
    pwr_on = 1'b1;
    for (int i = 0; i < 200 && cfg_done_q !== 1'b1; i++) @(negedge clk_sys);
    chk(cfg_done_q, 8'h01);
  endtask

  task automatic waitlk();
    for (int i = 0; i < 300 && {frac_pll_lock_out, int_pll_lock_out} !== 2'h3; i++)
      @(negedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic s_seq();
    ref_on = 1'b0;
    boot(SCP_LVL_FLOAT, SCP_LVL_FLOAT, 3'h0, 3'h0, 3'h1);
    chk(int_lock_en_q, 8'h01);
    repeat (40) @(negedge clk_sys);
    chk(8'(cal_seen), 8'h00);
    chk(frac_pll_lock_out, 8'h00);
    ref_on = 1'b1;
    waitlk();
    chk(8'(cal_seen), 8'h01);
    chk({int_pll_lock_out, frac_pll_lock_out}, 8'h03);
    chk({int_prescale_en_q, frac_prescale_en_q}, 8'h03);
    chk(grp_toggle_en_q, 8'h0f);
    boot(SCP_LVL_FLOAT, SCP_LVL_FLOAT, 3'h0, 3'h0, 3'h0);
    waitlk();
    chk(grp_toggle_en_q, 8'h00);
  endtask

  task automatic s_ports();
    logic [1:0] lv [3] = '{SCP_LVL_FLOAT, SCP_LVL_LOW, SCP_LVL_HIGH};
    int c;
    for (int a = 0; a < 3; a++) begin
      for (int b = 0; b < 3; b++) begin
        c = b + 3 * a;
        boot(lv[a], lv[b], 3'h0, 3'h0, 3'h1);
        chk(spi_active_q, c == 0 || c == 8);
        chk(i2c_active_q, c != 0 && c != 8);
        chk(spi_strap_load_q, c == 0);
        chk(sdio_3wire_q, c == 0 || c == 8);
        chk(regmap_access_en_q, 8'h01);
        if (c != 0 && c != 8) chk(i2c_addr_q, SCP_I2C_BASE + 7'(c - 1));
        {ps_a, ps_b} = {lv[(a + 1) % 3], lv[(b + 2) % 3]};
        repeat (10) @(negedge clk_sys);
        chk({spi_active_q, i2c_active_q}, c == 0 || c == 8 ? 8'h02 : 8'h01);
      end
    end
  endtask

  task automatic wr(input logic [14:0] ad, input logic [7:0] d);
    cfg_addr = ad;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic s_spicfg(input logic [1:0] a, input logic [7:0] exp);
    boot(a, a, 3'h0, 3'h0, 3'h1);
    chk(spi_cfg_q, SCP_SPI_CFG_RST);
    wr(15'h0001, 8'h33);
    chk(spi_cfg_q, SCP_SPI_CFG_RST);
    wr(SCP_SPI_CFG_ADDR, 8'h5a);
    chk(spi_cfg_q, exp);
  endtask

  // one nibble each: first, third, fourth strap, then {doubler, error} flags
  task automatic s_straps();
    logic [15:0] t [9] = '{16'h0622, 16'h1662, 16'h2631, 16'h3651, 16'h4700,
                           16'h0711, 16'h5760, 16'h2100, 16'h7771};
    foreach (t[i]) begin
      boot(SCP_LVL_HIGH, SCP_LVL_HIGH, t[i][14:12], t[i][10:8], t[i][6:4]);
      chk(cfg_err_q, t[i][0]);
      if (t[i][0] == 1'b0) chk(doubler_en_q, t[i][1]);
    end
    waitlk();
    chk(grp_toggle_en_q, 8'h00);
  endtask

  initial begin
    repeat (20) @(negedge clk_sys);
    dly = 4'h6;
    s_seq();
    dly = 4'h1;
    s_ports();
    s_spicfg(SCP_LVL_FLOAT, 8'h5a);
    s_spicfg(SCP_LVL_HIGH, 8'h5a);
    s_spicfg(SCP_LVL_LOW, SCP_SPI_CFG_RST);
    s_straps();
    final_report();
  end
endmodule
